// File: rtl/aiar_pkg.sv
package aiar_pkg;
  localparam int DW           = 16;
  localparam int CW           = 5;
  localparam int AW           = 4;
  localparam int LOSS_CNT_W   = 23;
  // Channel indices, listed in falling priority
  localparam int CH_V         = 0;
  localparam int CH_C         = 1;
  localparam int CH_V2        = 2;
  // Assignment codes
  localparam logic [CW-1:0] FN_NONE    = 5'h00;
  localparam logic [CW-1:0] FN_AUX1    = 5'h01;
  localparam logic [CW-1:0] FN_AUX2    = 5'h02;
  localparam logic [CW-1:0] FN_PID_SP  = 5'h03;
  localparam logic [CW-1:0] FN_PID_FB  = 5'h05;
  localparam logic [CW-1:0] FN_RATIO   = 5'h06;
  localparam logic [CW-1:0] FN_TLIM_A  = 5'h07;
  localparam logic [CW-1:0] FN_TLIM_B  = 5'h08;
  localparam logic [CW-1:0] FN_TRQ     = 5'h0A;
  localparam logic [CW-1:0] FN_TRQ_CUR = 5'h0B;
  localparam logic [CW-1:0] FN_MON     = 5'h14;
  // Register word addresses
  localparam logic [AW-1:0] ADDR_ASSIGN_V  = 4'h0;
  localparam logic [AW-1:0] ADDR_ASSIGN_C  = 4'h1;
  localparam logic [AW-1:0] ADDR_ASSIGN_V2 = 4'h2;
  localparam logic [AW-1:0] ADDR_SAVE_MODE = 4'h3;
  localparam logic [AW-1:0] ADDR_LOSS_RAT  = 4'h4;
  localparam logic [AW-1:0] ADDR_ANA_SEL   = 4'h5;
  localparam logic [AW-1:0] ADDR_SP_SRC    = 4'h6;
  localparam logic [AW-1:0] ADDR_STATUS    = 4'h7;
  localparam logic [AW-1:0] ADDR_MONITOR   = 4'h8;
  localparam logic [AW-1:0] ADDR_KEY_REF   = 4'h9;
  localparam logic [AW-1:0] ADDR_FL        = 4'hA;
  localparam logic [AW-1:0] ADDR_MON_GAIN  = 4'hB;
  // Reset values and figures
  localparam logic [9:0]    LOSS_RAT_RST   = 10'h3E7;
  localparam logic [9:0]    LOSS_DISABLED  = 10'h3E7;
  localparam logic [9:0]    LOSS_DECEL     = 10'h000;
  localparam logic [9:0]    LOSS_MIN       = 10'h014;
  localparam logic [9:0]    LOSS_MAX       = 10'h078;
  localparam logic [9:0]    LOSS_UNITY     = 10'h064;
  localparam logic [6:0]    PCT_DIV        = 7'h64;
  localparam logic [3:0]    BREAK_MUL      = 4'hA;
  localparam logic [2:0]    RECOV_DIV      = 3'h5;
  localparam logic [DW-1:0] MON_GAIN_RST   = 16'h0100;
  localparam int            MON_GAIN_SH    = 8;
  localparam int            RATIO_SH       = 12;
  localparam logic [1:0]    SP_SRC_ANALOG  = 2'h1;
  localparam int            LOSS_WIN_MS    = 400;
  localparam int            CLK_HZ         = 20000000;
  localparam int            LOSS_WIN_CYC   = LOSS_WIN_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    LS_NORMAL = 2'b01,
    LS_LOST   = 2'b10
  } aiar_loss_t;

  typedef struct packed {
    logic [DW-1:0] v;
    logic [DW-1:0] c;
    logic [DW-1:0] v2;
  } aiar_ana_t;

  typedef struct packed {
    logic [DW-1:0] freq_out;
    logic [DW-1:0] aux_freq;
    logic [DW-1:0] pid_sp;
    logic [DW-1:0] pid_fb;
    logic [DW-1:0] tlim_a;
    logic [DW-1:0] tlim_b;
    logic [DW-1:0] trq_cmd;
    logic [DW-1:0] trq_cur;
    logic [5:0]    vld;
    logic          ref_lost;
    logic          decel_stop;
  } aiar_out_t;
endpackage : aiar_pkg

// File: rtl/aiar_core.sv
// What this block does
// - Each channel takes its own assignment code; code 0 leaves it unused.
// - Code 1 adds the channel only to the first frequency source reference.
// - Code 2 adds the channel to every reference source.
// - Code 3 gives the PID setpoint, only with setpoint source set analog.
// - Code 5 gives the PID feedback value.
// - Code 6 gives a ratio multiplying the final frequency command.
// - Codes 7 and 8 give analog torque limits A and B.
// - Code 10 gives the torque command under torque control.
// - Code 11 gives the torque current command under torque control.
// - Code 20 gives a scaled monitor value readable over the bus only.
// - Duplicate codes resolve voltage over current over second voltage.
// - Save mode 0 stores keypad reference at main power-off.
// - Save mode 1 stores keypad reference only on save key press.
// - Drop below 10% of sampled level within 400 ms flags break.
// - On break, run at loss ratio times sampled level.
// - Rising above recovery threshold ends the break state.
// - Analog level is resampled every window as break reference.
// - Loss ratio takes 0 (stop), 20 to 120 percent, or 999 (off).
// - Ratio 999 flags the loss but keeps following the analog command.
// - Ratio 0 or 999 recovers above one fifth of the sample.
// - Ratio of 100 percent or more recovers above the full sample.
// - Loss detection reads unfiltered inputs, unaffected by filter settings.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module aiar_core
  import aiar_pkg::*;
#(
  parameter int unsigned LOSS_WIN = LOSS_WIN_CYC
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          clk_en,
  input  wire logic [AW-1:0] bus_addr,
  input  wire logic [DW-1:0] bus_wdata,
  input  wire logic          bus_wr,
  input  wire logic          bus_rd,
  output var  logic [DW-1:0] bus_rdata,
  input  wire aiar_ana_t     ain,
  input  wire logic [DW-1:0] freq_ref_in,
  input  wire logic          ref_src_first,
  input  wire logic          ref_src_analog,
  input  wire logic          save_key_pin,
  input  wire logic          main_pwr_off_pin,
  input  wire logic [DW-1:0] nv_restore_data,
  output var  logic          nv_store_stb,
  output var  logic [DW-1:0] nv_store_data,
  output var  aiar_out_t     drv
);

  typedef struct packed {
    logic [2:0][CW-1:0]    asg;
    logic                  save_mode;
    logic [9:0]            loss_rat;
    logic [1:0]            ana_sel;
    logic [1:0]            sp_src;
    logic [DW-1:0]         mon_gain;
    logic [DW-1:0]         mon;
    logic [DW-1:0]         key_ref;
    logic                  restore_pend;
    logic [2:0]            key_sync;
    logic [2:0]            off_sync;
    aiar_loss_t            ls;
    logic [LOSS_CNT_W-1:0] cnt;
    logic [DW-1:0]         fl;
    logic [DW-1:0]         rdata;
    logic                  st_stb;
    logic [DW-1:0]         st_data;
    aiar_out_t             o;
  } aiar_state_t;

  aiar_state_t st_q;
  aiar_state_t st_d;

  function automatic logic [DW:0] pick_fn(
    input logic [2:0][CW-1:0] asg,
    input aiar_ana_t          a,
    input logic [CW-1:0]      code
  );
    logic [DW:0] r;
    r = '0;
    if (asg[CH_V2] == code) r = {1'b1, a.v2};
    if (asg[CH_C] == code) r = {1'b1, a.c};
    if (asg[CH_V] == code) r = {1'b1, a.v};
    return r;
  endfunction : pick_fn

  function automatic logic [DW-1:0] sat_fn(input logic [39:0] x);
    logic [DW-1:0] r;
    r = (x > 40'(16'hFFFF)) ? 16'hFFFF : x[DW-1:0];
    return r;
  endfunction : sat_fn

  logic [DW:0]           p_aux1;
  logic [DW:0]           p_aux2;
  logic [DW:0]           p_sp;
  logic [DW:0]           p_fb;
  logic [DW:0]           p_rat;
  logic [DW:0]           p_tla;
  logic [DW:0]           p_tlb;
  logic [DW:0]           p_trq;
  logic [DW:0]           p_trc;
  logic [DW:0]           p_mon;
  logic [DW-1:0]         ana;
  logic                  loss_off;
  logic                  loss_stop;
  logic [DW-1:0]         thr;
  logic [DW-1:0]         runf;
  logic                  brk;
  logic                  recov;
  logic                  win_end;
  logic [DW-1:0]         base;
  logic [DW+1:0]         sum;
  logic                  key_rise;
  logic                  off_rise;

  always_comb begin
    // Priority resolution per code
    p_aux1 = pick_fn(st_q.asg, ain, FN_AUX1);
    p_aux2 = pick_fn(st_q.asg, ain, FN_AUX2);
    p_sp   = pick_fn(st_q.asg, ain, FN_PID_SP);
    p_fb   = pick_fn(st_q.asg, ain, FN_PID_FB);
    p_rat  = pick_fn(st_q.asg, ain, FN_RATIO);
    p_tla  = pick_fn(st_q.asg, ain, FN_TLIM_A);
    p_tlb  = pick_fn(st_q.asg, ain, FN_TLIM_B);
    p_trq  = pick_fn(st_q.asg, ain, FN_TRQ);
    p_trc  = pick_fn(st_q.asg, ain, FN_TRQ_CUR);
    p_mon  = pick_fn(st_q.asg, ain, FN_MON);
    // Raw analog frequency command, no filtering
    case (st_q.ana_sel)
      2'h1:    ana = ain.c;
      2'h2:    ana = ain.v2;
      default: ana = ain.v;
    endcase
    // Out-of-range ratios behave as disabled
    loss_stop = (st_q.loss_rat == LOSS_DECEL);
    loss_off  = !loss_stop && ((st_q.loss_rat < LOSS_MIN)
                || (st_q.loss_rat > LOSS_MAX));
    if (loss_stop || loss_off) begin
      thr = st_q.fl / DW'(RECOV_DIV);
    end else if (st_q.loss_rat >= LOSS_UNITY) begin
      thr = st_q.fl;
    end else begin
      thr = DW'((26'(st_q.fl) * 26'(st_q.loss_rat)) / 26'(PCT_DIV));
    end
    if (loss_stop) begin
      runf = '0;
    end else if (loss_off) begin
      runf = ana;
    end else begin
      runf = sat_fn(40'((26'(st_q.fl) * 26'(st_q.loss_rat))
                    / 26'(PCT_DIV)));
    end
    brk     = (st_q.fl != '0)
              && ((20'(ana) * 20'(BREAK_MUL)) < 20'(st_q.fl));
    recov   = (ana > thr);
    win_end = (st_q.cnt == LOSS_CNT_W'(LOSS_WIN - 1));
    key_rise = st_q.key_sync[1] && !st_q.key_sync[2];
    off_rise = st_q.off_sync[1] && !st_q.off_sync[2];

    st_d = st_q;
    st_d.key_sync = {st_q.key_sync[1:0], save_key_pin};
    st_d.off_sync = {st_q.off_sync[1:0], main_pwr_off_pin};
    st_d.st_stb   = 1'b0;
    st_d.rdata    = '0;

    // Register writes
    if (bus_wr) begin
      case (bus_addr)
        ADDR_ASSIGN_V:  st_d.asg[CH_V] = bus_wdata[CW-1:0];
        ADDR_ASSIGN_C:  st_d.asg[CH_C] = bus_wdata[CW-1:0];
        ADDR_ASSIGN_V2: st_d.asg[CH_V2] = bus_wdata[CW-1:0];
        ADDR_SAVE_MODE: st_d.save_mode = bus_wdata[0];
        ADDR_LOSS_RAT:  st_d.loss_rat = bus_wdata[9:0];
        ADDR_ANA_SEL:   st_d.ana_sel = bus_wdata[1:0];
        ADDR_SP_SRC:    st_d.sp_src = bus_wdata[1:0];
        ADDR_KEY_REF:   st_d.key_ref = bus_wdata;
        ADDR_MON_GAIN:  st_d.mon_gain = bus_wdata;
        default: ;
      endcase
    end
    // Register reads, data in the next cycle
    if (bus_rd) begin
      case (bus_addr)
        ADDR_ASSIGN_V:  st_d.rdata = DW'(st_q.asg[CH_V]);
        ADDR_ASSIGN_C:  st_d.rdata = DW'(st_q.asg[CH_C]);
        ADDR_ASSIGN_V2: st_d.rdata = DW'(st_q.asg[CH_V2]);
        ADDR_SAVE_MODE: st_d.rdata = DW'(st_q.save_mode);
        ADDR_LOSS_RAT:  st_d.rdata = DW'(st_q.loss_rat);
        ADDR_ANA_SEL:   st_d.rdata = DW'(st_q.ana_sel);
        ADDR_SP_SRC:    st_d.rdata = DW'(st_q.sp_src);
        ADDR_STATUS:    st_d.rdata = DW'({st_q.o.decel_stop,
                                          st_q.o.ref_lost});
        ADDR_MONITOR:   st_d.rdata = st_q.mon;
        ADDR_KEY_REF:   st_d.rdata = st_q.key_ref;
        ADDR_FL:        st_d.rdata = st_q.fl;
        ADDR_MON_GAIN:  st_d.rdata = st_q.mon_gain;
        default:        st_d.rdata = '0;
      endcase
    end

    // Keypad reference restore and save
    if (st_q.restore_pend) begin
      st_d.key_ref      = nv_restore_data;
      st_d.restore_pend = 1'b0;
    end
    if ((!st_q.save_mode && off_rise)
        || (st_q.save_mode && key_rise)) begin
      st_d.st_stb  = 1'b1;
      st_d.st_data = st_q.key_ref;
    end

    // Reference loss detection
    case (st_q.ls)
      LS_NORMAL: begin
        if (ref_src_analog && brk) begin
          st_d.ls  = LS_LOST;
          st_d.cnt = '0;
        end else if (win_end) begin
          st_d.cnt = '0;
          st_d.fl  = ana;
        end else begin
          st_d.cnt = st_q.cnt + 1'b1;
        end
      end
      LS_LOST: begin
        if (!ref_src_analog || recov) begin
          st_d.ls  = LS_NORMAL;
          st_d.cnt = '0;
          st_d.fl  = ana;
        end
      end
      default: begin
        st_d.ls  = LS_NORMAL;
        st_d.cnt = '0;
      end
    endcase

    // Frequency path
    if (!ref_src_analog) begin
      base = freq_ref_in;
    end else if (st_d.ls == LS_LOST) begin
      base = runf;
    end else begin
      base = ana;
    end
    sum = (DW+2)'(base)
          + ((DW+2)'(p_aux2[DW-1:0]) & {(DW+2){p_aux2[DW]}})
          + ((DW+2)'(p_aux1[DW-1:0])
             & {(DW+2){p_aux1[DW] && ref_src_first}});
    st_d.o.aux_freq = sat_fn(40'(sum) - 40'(base));
    if (st_d.ls == LS_LOST && loss_stop && ref_src_analog) begin
      st_d.o.freq_out = '0;
    end else if (p_rat[DW]) begin
      st_d.o.freq_out = sat_fn(40'((40'(sum) * 40'(p_rat[DW-1:0]))
                                   >> RATIO_SH));
    end else begin
      st_d.o.freq_out = sat_fn(40'(sum));
    end
    st_d.o.ref_lost   = (st_d.ls == LS_LOST);
    st_d.o.decel_stop = (st_d.ls == LS_LOST) && loss_stop
                        && ref_src_analog;
    // Function outputs with their valid bits
    st_d.o.pid_sp  = p_sp[DW-1:0];
    st_d.o.vld[0]  = p_sp[DW] && (st_q.sp_src == SP_SRC_ANALOG);
    st_d.o.pid_fb  = p_fb[DW-1:0];
    st_d.o.vld[1]  = p_fb[DW];
    st_d.o.tlim_a  = p_tla[DW-1:0];
    st_d.o.vld[2]  = p_tla[DW];
    st_d.o.tlim_b  = p_tlb[DW-1:0];
    st_d.o.vld[3]  = p_tlb[DW];
    st_d.o.trq_cmd = p_trq[DW-1:0];
    st_d.o.vld[4]  = p_trq[DW];
    st_d.o.trq_cur = p_trc[DW-1:0];
    st_d.o.vld[5]  = p_trc[DW];
    st_d.mon = p_mon[DW] ? sat_fn(40'((40'(p_mon[DW-1:0])
                          * 40'(st_q.mon_gain)) >> MON_GAIN_SH))
                         : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q              <= '0;
      st_q.loss_rat     <= LOSS_RAT_RST;
      st_q.mon_gain     <= MON_GAIN_RST;
      st_q.restore_pend <= 1'b1;
      st_q.ls           <= LS_NORMAL;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign bus_rdata     = st_q.rdata;
  assign nv_store_stb  = st_q.st_stb;
  assign nv_store_data = st_q.st_data;
  assign drv           = st_q.o;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_key_press;
    clk_en && st_q.save_mode && key_rise;
  endsequence

  sequence s_off_event;
    clk_en && !st_q.save_mode && off_rise;
  endsequence

  a_break_detect: assert property (
    clk_en && st_q.ls == LS_NORMAL && ref_src_analog && brk
    |=> drv.ref_lost && st_q.ls == LS_LOST)
    else $error("break not flagged");

  a_recover_exit: assert property (
    clk_en && st_q.ls == LS_LOST && recov |=> !drv.ref_lost)
    else $error("recovery not taken");

  a_lost_flag_hold: assert property (
    drv.ref_lost == (st_q.ls == LS_LOST))
    else $error("loss flag out of step with state");

  a_decel_zero: assert property (
    drv.decel_stop |-> drv.freq_out == '0 && drv.ref_lost)
    else $error("decel stop with nonzero frequency");

  a_sample_refresh: assert property (
    clk_en && st_q.ls == LS_NORMAL && win_end
    && !(ref_src_analog && brk) |=> st_q.fl == $past(ana))
    else $error("sample not refreshed");

  a_key_store: assert property (
    s_key_press |=> nv_store_stb && nv_store_data == $past(st_q.key_ref))
    else $error("save key did not store");

  a_off_store: assert property (
    s_off_event |=> nv_store_stb ##1 !nv_store_stb || !clk_en)
    else $error("power-off store missing");

  a_prio_voltage: assert property (
    clk_en && st_q.asg[CH_V] == FN_PID_FB
    |=> drv.vld[1] && drv.pid_fb == $past(ain.v))
    else $error("voltage channel lost priority");

  a_read_status: assert property (
    clk_en && bus_rd && bus_addr == ADDR_STATUS
    |=> bus_rdata[0] == $past(drv.ref_lost))
    else $error("status read mismatch");

  a_aux1_gate: assert property (
    clk_en && !ref_src_first && !p_aux2[DW] |=> drv.aux_freq == '0)
    else $error("aux1 term applied to other source");

  a_aux2_all: assert property (
    clk_en && p_aux2[DW] && !(p_aux1[DW] && ref_src_first)
    |=> drv.aux_freq == $past(p_aux2[DW-1:0]))
    else $error("aux2 term missing");

  a_sp_src_gate: assert property (
    clk_en && st_q.sp_src != SP_SRC_ANALOG |=> !drv.vld[0])
    else $error("setpoint valid without analog source");

  a_mon_unused: assert property (
    clk_en && !p_mon[DW] |=> st_q.mon == '0)
    else $error("monitor value without monitor channel");

  a_restore_ref: assert property (
    clk_en && st_q.restore_pend
    |=> !st_q.restore_pend && st_q.key_ref == $past(nv_restore_data))
    else $error("keypad reference not restored");

  a_loss_run: assert property (
    clk_en && ref_src_analog && st_q.ls == LS_LOST && !recov
    && !loss_stop && !loss_off && !p_aux1[DW] && !p_aux2[DW]
    && !p_rat[DW] |=> drv.freq_out == $past(runf))
    else $error("run frequency not ratio of sample");

endmodule : aiar_core
`default_nettype wire

// File: dv/aiar_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module aiar_src_model
  import aiar_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire aiar_ana_t tgt,
  input  wire logic      glide,
  output var  aiar_ana_t ain
);
  localparam logic [DW-1:0] STEP = 16'h0040;

  // Jump, or glide in small steps towards the target
  function automatic logic [DW-1:0] mv(logic [DW-1:0] c, logic [DW-1:0] t);
    if (!glide || (c > t ? c - t : t - c) <= STEP) begin
      return t;
    end
    return c > t ? c - STEP : c + STEP;
  endfunction : mv

  initial ain = '0;
  always @(posedge ref_clk) begin
    ain.v  <= mv(ain.v, tgt.v);
    ain.c  <= mv(ain.c, tgt.c);
    ain.v2 <= mv(ain.v2, tgt.v2);
  end
endmodule : aiar_src_model
`default_nettype wire

// File: dv/test_analog_input_assign_refloss.sv
`timescale 1ns/10ps
`default_nettype none
module test_analog_input_assign_refloss
  import aiar_pkg::*;
;
  localparam int LW = 32;
  logic            ref_clk = 1'b0;
  logic            rst = 1'b1;
  logic            clk_en = 1'b1;
  logic [AW-1:0]   bus_addr = '0;
  logic [DW-1:0]   bus_wdata = '0;
  logic            bus_wr = 1'b0;
  logic            bus_rd = 1'b0;
  logic [DW-1:0]   bus_rdata;
  aiar_ana_t       ain;
  aiar_ana_t       tgt = '0;
  logic            glide = 1'b0;
  logic [DW-1:0]   freq_ref_in = 16'h0400;
  logic            ref_src_first = 1'b0;
  logic            ref_src_analog = 1'b0;
  logic            save_key_pin = 1'b0;
  logic            main_pwr_off_pin = 1'b0;
  logic [DW-1:0]   nv_restore_data = 16'h0123;
  logic            nv_store_stb;
  logic [DW-1:0]   nv_store_data;
  aiar_out_t       drv;
  int              fail_count = 0;
  int              checked = 0;
  logic [31:0]     seed = 32'h27C67076;

  always #25 ref_clk = ~ref_clk;

  aiar_core #(.LOSS_WIN(LW)) i_aiar_core (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .ain(ain), .freq_ref_in(freq_ref_in),
    .ref_src_first(ref_src_first), .ref_src_analog(ref_src_analog),
    .save_key_pin(save_key_pin), .main_pwr_off_pin(main_pwr_off_pin),
    .nv_restore_data(nv_restore_data), .nv_store_stb(nv_store_stb),
    .nv_store_data(nv_store_data), .drv(drv));

  aiar_src_model i_aiar_src_model (
    .ref_clk(ref_clk), .tgt(tgt), .glide(glide), .ain(ain));

  function automatic logic [DW-1:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return {4'h0, seed[11:0]};
  endfunction : rnd

  function automatic logic [DW-1:0] fsel(int i);
    case (i)
      0: return drv.pid_sp;
      1: return drv.pid_fb;
      2: return drv.tlim_a;
      3: return drv.tlim_b;
      4: return drv.trq_cmd;
      default: return drv.trq_cur;
    endcase
  endfunction : fsel

  task automatic end_sim();
    $display("Counts: %0d checks, %0d mismatches", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
    @(posedge ref_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rchk(string nm, logic [AW-1:0] a, logic [DW-1:0] e);
    @(posedge ref_clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 chk(nm, bus_rdata, e);
  endtask : rchk

  task automatic asg(int k, logic [CW-1:0] code);
    wr(ADDR_ASSIGN_V + AW'(k), {11'h000, code});
    cyc(3);
  endtask : asg

  task automatic wait_lost(logic e);
    int n;
    n = 0;
    while (drv.ref_lost !== e && n < 4 * LW) begin
      cyc(1);
      n++;
    end
    if (drv.ref_lost !== e) begin
      chk("ref_lost wait", drv.ref_lost, e);
      end_sim();
    end
  endtask : wait_lost

  task automatic store(logic key, int exp_n, logic [DW-1:0] d);
    int n;
    n = 0;
    cyc(1);
    if (key) save_key_pin <= 1'b1;
    else main_pwr_off_pin <= 1'b1;
    repeat (8) begin
      cyc(1);
      n += int'(nv_store_stb === 1'b1);
    end
    save_key_pin     <= 1'b0;
    main_pwr_off_pin <= 1'b0;
    chk("store pulses", n, exp_n);
    if (exp_n > 0) chk("store data", nv_store_data, d);
  endtask : store

  logic [CW-1:0] codes [6] = '{FN_PID_SP, FN_PID_FB, FN_TLIM_A, FN_TLIM_B,
                               FN_TRQ, FN_TRQ_CUR};
  logic [9:0]    rat [4] = '{10'h032, 10'h3E7, 10'h000, 10'h078};
  logic [DW-1:0] run [4] = '{16'h01F4, 16'h0032, 16'h0000, 16'h04B0};
  logic [DW-1:0] thr [4] = '{16'h01F4, 16'h00C8, 16'h00C8, 16'h03E8};

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    cyc(2);
    // Reset values, gated strobe, unmapped read
    rchk("loss_rat", ADDR_LOSS_RAT, 16'h03E7);
    rchk("mon_gain", ADDR_MON_GAIN, MON_GAIN_RST);
    rchk("restore", ADDR_KEY_REF, 16'h0123);
    rchk("unmapped", 4'hF, 16'h0000);
    clk_en <= 1'b0;
    wr(ADDR_LOSS_RAT, 16'h0032);
    clk_en <= 1'b1;
    rchk("gated wr", ADDR_LOSS_RAT, 16'h03E7);
    $display("done: reset");
    // Function codes on the voltage channel
    wr(ADDR_SP_SRC, 16'h0000);
    asg(0, FN_PID_SP);
    chk("sp no src", drv.vld, 6'h00);
    wr(ADDR_SP_SRC, {14'h0000, SP_SRC_ANALOG});
    foreach (codes[i]) begin
      tgt.v <= rnd();
      asg(0, codes[i]);
      chk("vld", drv.vld, 6'h01 << i);
      chk("value", fsel(i), tgt.v);
    end
    asg(0, FN_NONE);
    chk("none vld", drv.vld, 6'h00);
    chk("none freq", drv.freq_out, freq_ref_in);
    $display("done: codes");
    // Duplicates resolve v over c over v2
    tgt <= {rnd(), rnd(), rnd()};
    for (int k = 0; k < 3; k++) asg(k, FN_PID_FB);
    chk("prio v", drv.pid_fb, tgt.v);
    asg(0, FN_NONE);
    chk("prio c", drv.pid_fb, tgt.c);
    asg(1, FN_NONE);
    chk("prio v2", drv.pid_fb, tgt.v2);
    asg(2, FN_NONE);
    $display("done: priority");
    // Auxiliary terms, ratio, monitor
    ref_src_first <= 1'b1;
    asg(1, FN_AUX1);
    chk("aux1 first", drv.freq_out, freq_ref_in + tgt.c);
    chk("aux1 term", drv.aux_freq, tgt.c);
    ref_src_first <= 1'b0;
    cyc(3);
    chk("aux1 other", drv.freq_out, freq_ref_in);
    chk("aux1 off", drv.aux_freq, 16'h0000);
    asg(1, FN_AUX2);
    chk("aux2", drv.freq_out, freq_ref_in + tgt.c);
    chk("aux2 term", drv.aux_freq, tgt.c);
    asg(2, FN_RATIO);
    chk("ratio", drv.freq_out,
        16'((32'(freq_ref_in + tgt.c) * 32'(tgt.v2)) >> 12));
    asg(1, FN_NONE);
    asg(2, FN_NONE);
    asg(0, FN_MON);
    chk("mon freq", drv.freq_out, freq_ref_in);
    rchk("monitor", ADDR_MONITOR, tgt.v);
    wr(ADDR_MON_GAIN, 16'h0200);
    rchk("monitor x2", ADDR_MONITOR, {tgt.v[14:0], 1'b0});
    asg(0, FN_NONE);
    $display("done: functions");
    // Keypad reference saving modes
    wr(ADDR_KEY_REF, 16'h0555);
    wr(ADDR_SAVE_MODE, 16'h0000);
    store(1'b0, 1, 16'h0555);
    wr(ADDR_SAVE_MODE, 16'h0001);
    wr(ADDR_KEY_REF, 16'h0666);
    store(1'b0, 0, 16'h0000);
    store(1'b1, 1, 16'h0666);
    $display("done: save");
    // Reference loss for each ratio class
    ref_src_analog <= 1'b1;
    wr(ADDR_ANA_SEL, 16'h0000);
    foreach (rat[i]) begin
      wr(ADDR_LOSS_RAT, {6'h00, rat[i]});
      tgt.v <= 16'h03E8;
      cyc(2 * LW + 4);
      rchk("sample", ADDR_FL, 16'h03E8);
      tgt.v <= 16'h0032;
      wait_lost(1'b1);
      cyc(2);
      chk("run freq", drv.freq_out, run[i]);
      chk("decel", drv.decel_stop, rat[i] == 10'h000);
      rchk("status", ADDR_STATUS, {14'h0, rat[i] == 10'h000, 1'b1});
      rchk("held", ADDR_FL, 16'h03E8);
      glide <= 1'b1;
      tgt.v <= thr[i];
      cyc(LW);
      chk("at thr", drv.ref_lost, 1'b1);
      tgt.v <= thr[i] + 16'h0001;
      wait_lost(1'b0);
      cyc(2);
      chk("follow", drv.freq_out, thr[i] + 16'h0001);
      glide <= 1'b0;
    end
    // Analog command taken from the other two channels
    tgt.c  <= 16'h0700;
    tgt.v2 <= 16'h0600;
    for (int s = 1; s < 3; s++) begin
      wr(ADDR_ANA_SEL, 16'(s));
      cyc(3);
      chk("ana sel", drv.freq_out, s == 1 ? 16'h0700 : 16'h0600);
    end
    $display("done: loss");
    end_sim();
  end
endmodule : test_analog_input_assign_refloss
`default_nettype wire
